/* pkg/fawp_params.svh */
`ifndef FAWP_PARAMS_SVH
`define FAWP_PARAMS_SVH
// register byte offsets
`define FAWP_CFG_OFS 8'h00
`define FAWP_STAT_OFS 8'h04
`define FAWP_ADDR_OFS 8'h08
`define FAWP_CNT_OFS 8'h0C
// configuration fields and reset
`define FAWP_CFG_RST 7'h00
`define FAWP_CFG_SCHEME 0
`define FAWP_CFG_CMP 1
`define FAWP_CFG_GRAN 2
`define FAWP_CFG_TB 3
`define FAWP_CFG_LVL 6:4
// lock bits, all set after reset
`define FAWP_NLOCK 94
`define FAWP_LOCK_RST {94{1'b1}}
// bus responses
`define FAWP_RESP_OKAY 2'h0
`define FAWP_RESP_SLVERR 2'h2
// opcodes
`define FAWP_OPC_LOCK 8'h36
`define FAWP_OPC_UNLOCK 8'h39
`define FAWP_OPC_PP 8'h02
`define FAWP_OPC_PP_DUAL 8'hA2
`define FAWP_OPC_PP_QUAD 8'h32
`define FAWP_OPC_SEQ_A 8'hAF
`define FAWP_OPC_SEQ_B 8'hAD
`define FAWP_OPC_E4K 8'h20
`define FAWP_OPC_E32K 8'h52
`define FAWP_OPC_E64K 8'hD8
`define FAWP_OPC_CHIP_A 8'h60
`define FAWP_OPC_CHIP_B 8'hC7
// link bit counts
`define FAWP_BIT_OPC 6'h07
`define FAWP_BIT_ADDR 6'h1F
`define FAWP_BIT_SAT 6'h20
// array geometry
`define FAWP_ARRAY 23'h400000
`define FAWP_SZ_PAGE 23'h000100
`define FAWP_SZ_4K 23'h001000
`define FAWP_SZ_32K 23'h008000
`define FAWP_SZ_64K 23'h010000
`define FAWP_TOP_BLK 6'h3F
`define FAWP_TOP_BASE 23'h3F0000
`endif

/* pkg/fawp_pkg.sv */
package fawp_pkg;
  typedef enum logic [2:0] {
    fawp_op_none,
    fawp_op_prog,
    fawp_op_e4k,
    fawp_op_e32k,
    fawp_op_e64k,
    fawp_op_chip,
    fawp_op_lock,
    fawp_op_unlock
  } fawp_op_e;
  typedef logic [22:0] fawp_span_t;
endpackage

/* design/fawp_top.sv */
// Summary of operation
// - scheme bit clear: region fields decide protection
// - scheme bit set: per-block lock bits decide
// - complement bit inverts the protected region
// - granularity bit picks 64 kB or 4 kB units
// - top/bottom bit picks high or low end
// - level field sizes region; refuse protected writes
// - 64 kB levels: none, 64k..2M, whole array
// - 4 kB levels: 4k..32k, 32k, then whole
// - addresses outside the region stay writable
// - complement protects the rest; level 0 all
// - complement 4 kB: 110/111 none, 100/101 rest
// - complement 4 kB 32 kB erase widened window
// - complement 4 kB 64 kB erase widened window
// - all lock bits set after reset
// - 4 kB locks in blocks 0/63, else 64 kB
`include "fawp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module fawp_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic link_si,
  output logic op_start,
  output logic op_refused,
  output fawp_pkg::fawp_op_e op_kind,
  output logic [23:0] op_addr
);
  import fawp_pkg::*;

  function automatic fawp_op_e opc_decode(input logic [7:0] opc);
    fawp_op_e k;
    k = fawp_op_none;
    unique case (opc)
      `FAWP_OPC_PP, `FAWP_OPC_PP_DUAL, `FAWP_OPC_PP_QUAD,
      `FAWP_OPC_SEQ_A, `FAWP_OPC_SEQ_B: k = fawp_op_prog;
      `FAWP_OPC_E4K: k = fawp_op_e4k;
      `FAWP_OPC_E32K: k = fawp_op_e32k;
      `FAWP_OPC_E64K: k = fawp_op_e64k;
      `FAWP_OPC_CHIP_A, `FAWP_OPC_CHIP_B: k = fawp_op_chip;
      `FAWP_OPC_LOCK: k = fawp_op_lock;
      `FAWP_OPC_UNLOCK: k = fawp_op_unlock;
      default: k = fawp_op_none;
    endcase
    return k;
  endfunction

  // which lock bit covers an address
  function automatic logic [6:0] lock_idx(input logic [23:0] a);
    logic [6:0] idx;
    idx = 7'h00;
    if (a[21:16] == 6'h00) begin
      idx = {3'h0, a[15:12]};
    end else if (a[21:16] == `FAWP_TOP_BLK) begin
      idx = 7'h10 + {3'h0, a[15:12]};
    end else begin
      idx = {1'b0, a[21:16]} + 7'h1F;
    end
    return idx;
  endfunction

  // ---------------- link domain ----------------
  logic [5:0] bit_cnt_reg;
  logic [30:0] shift_reg;
  logic [31:0] frame_word_reg;
  logic req_tgl_reg;
  logic [7:0] opc_now;
  logic [7:0] opc_full;

  assign opc_now = {shift_reg[6:0], link_si};
  assign opc_full = shift_reg[30:23];

  // frame state ends with the frame by its own select
  always_ff @(posedge link_sck or posedge link_cs_n) begin
    if (link_cs_n) begin
      bit_cnt_reg <= 6'h00;
      shift_reg <= 31'h00000000;
    end else begin
      if (bit_cnt_reg != `FAWP_BIT_SAT) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      shift_reg <= {shift_reg[29:0], link_si};
    end
  end

  // captured command stays put until the next frame
  always_ff @(posedge link_sck or posedge rst) begin
    if (rst) begin
      frame_word_reg <= 32'h00000000;
      req_tgl_reg <= 1'b0;
    end else if (!link_cs_n) begin
      if (bit_cnt_reg == `FAWP_BIT_OPC &&
          opc_decode(opc_now) == fawp_op_chip) begin
        frame_word_reg <= {opc_now, 24'h000000};
        req_tgl_reg <= ~req_tgl_reg;
      end else if (bit_cnt_reg == `FAWP_BIT_ADDR &&
                   opc_decode(opc_full) != fawp_op_none &&
                   opc_decode(opc_full) != fawp_op_chip) begin
        frame_word_reg <= {shift_reg, link_si};
        req_tgl_reg <= ~req_tgl_reg;
      end
    end
  end

  // ---------------- core domain ----------------
  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic ev;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= req_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end
  assign ev = tgl_s2_reg ^ tgl_s3_reg;

  logic [6:0] cfg_reg;
  logic [`FAWP_NLOCK-1:0] lock_reg;
  fawp_op_e cmd_kind;
  logic [23:0] cmd_addr;
  logic cmd_wr;

  assign cmd_kind = opc_decode(frame_word_reg[31:24]);
  assign cmd_addr = frame_word_reg[23:0];
  assign cmd_wr = cmd_kind inside {fawp_op_prog, fawp_op_e4k, fawp_op_e32k,
                                   fawp_op_e64k, fawp_op_chip};

  // unprotected-or-protected window size for a level
  function automatic fawp_span_t win_size(input logic g4,
                                          input logic [2:0] lv);
    fawp_span_t s;
    s = 23'h000000;
    if (lv == 3'h0) begin
      s = 23'h000000;
    end else if (!g4) begin
      if (lv == 3'h7) begin
        s = `FAWP_ARRAY;
      end else begin
        s = `FAWP_SZ_64K << (lv - 3'h1);
      end
    end else begin
      if (lv >= 3'h6) begin
        s = `FAWP_ARRAY;
      end else if (lv == 3'h5) begin
        s = `FAWP_SZ_32K;
      end else begin
        s = `FAWP_SZ_4K << (lv - 3'h1);
      end
    end
    return s;
  endfunction

  fawp_span_t span;
  fawp_span_t op_lo;
  fawp_span_t op_hi;
  fawp_span_t win;
  fawp_span_t win_lo;
  logic inside_win;
  logic touch_win;
  logic std_block;
  logic ind_block;
  logic blocked;
  logic [`FAWP_NLOCK-1:0] lock_hit;

  always_comb begin
    unique case (cmd_kind)
      fawp_op_e4k: span = `FAWP_SZ_4K;
      fawp_op_e32k: span = `FAWP_SZ_32K;
      fawp_op_e64k: span = `FAWP_SZ_64K;
      fawp_op_chip: span = `FAWP_ARRAY;
      default: span = `FAWP_SZ_PAGE;
    endcase
    op_lo = {1'b0, cmd_addr[21:0]} & ~(span - 23'h000001);
    op_hi = op_lo + span - 23'h000001;
    win = win_size(cfg_reg[`FAWP_CFG_GRAN], cfg_reg[`FAWP_CFG_LVL]);
    // complement with 4 kB units lets block erases use a wider window
    if (cfg_reg[`FAWP_CFG_CMP] && cfg_reg[`FAWP_CFG_GRAN] &&
        win != 23'h000000) begin
      if (cmd_kind == fawp_op_e32k && win < `FAWP_SZ_32K) begin
        win = `FAWP_SZ_32K;
      end
      if (cmd_kind == fawp_op_e64k && win < `FAWP_SZ_64K) begin
        win = `FAWP_SZ_64K;
      end
    end
    win_lo = `FAWP_ARRAY - win;
    if (cfg_reg[`FAWP_CFG_TB]) begin
      inside_win = op_hi < win;
      touch_win = op_lo < win;
    end else begin
      inside_win = op_lo >= win_lo;
      touch_win = op_hi >= win_lo;
    end
    // complement: anything not wholly inside the window is protected
    std_block = cfg_reg[`FAWP_CFG_CMP] ? !inside_win :
                touch_win;
    ind_block = |(lock_reg & lock_hit);
    blocked = cfg_reg[`FAWP_CFG_SCHEME] ? ind_block : std_block;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FAWP_NLOCK; gi++) begin : g_lock_span
      localparam fawp_span_t LO = (gi < 16) ? fawp_span_t'(gi * 4096) :
        (gi < 32) ? fawp_span_t'(32'h3F0000 + (gi - 16) * 4096) :
        fawp_span_t'((gi - 31) * 65536);
      localparam fawp_span_t HI = (gi < 32) ? LO + 23'h000FFF :
        LO + 23'h00FFFF;
      assign lock_hit[gi] = (LO <= op_hi) && (HI >= op_lo);
    end
  endgenerate

  logic start_reg;
  logic refused_reg;
  fawp_op_e kind_reg;
  logic [23:0] addr_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
      refused_reg <= 1'b0;
      kind_reg <= fawp_op_none;
      addr_reg <= 24'h000000;
    end else begin
      start_reg <= ev && cmd_wr && !blocked;
      refused_reg <= ev && cmd_wr && blocked;
      if (ev) begin
        kind_reg <= cmd_kind;
        addr_reg <= cmd_addr;
      end
    end
  end
  assign op_start = start_reg;
  assign op_refused = refused_reg;
  assign op_kind = kind_reg;
  assign op_addr = addr_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_reg <= `FAWP_LOCK_RST;
    end else if (ev && cmd_kind == fawp_op_lock) begin
      lock_reg[lock_idx(cmd_addr)] <= 1'b1;
    end else if (ev && cmd_kind == fawp_op_unlock) begin
      lock_reg[lock_idx(cmd_addr)] <= 1'b0;
    end
  end

  logic last_refused_reg;
  logic seen_reg;
  logic [7:0] last_opc_reg;
  logic [15:0] refused_cnt_reg;
  logic [15:0] started_cnt_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_refused_reg <= 1'b0;
      seen_reg <= 1'b0;
      last_opc_reg <= 8'h00;
      refused_cnt_reg <= 16'h0000;
      started_cnt_reg <= 16'h0000;
    end else if (ev && cmd_wr) begin
      last_refused_reg <= blocked;
      seen_reg <= 1'b1;
      last_opc_reg <= frame_word_reg[31:24];
      if (blocked) begin
        refused_cnt_reg <= refused_cnt_reg + 16'h0001;
      end else begin
        started_cnt_reg <= started_cnt_reg + 16'h0001;
      end
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic awready_reg;
  logic wready_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;

  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_got_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else begin
      if (do_write) begin
        aw_got_reg <= 1'b0;
      end
      if (bvalid_reg && s_axi_bready) begin
        awready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wready_reg <= 1'b1;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb0_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_got_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb0_reg <= s_axi_wstrb[0];
    end else begin
      if (do_write) begin
        w_got_reg <= 1'b0;
      end
      if (bvalid_reg && s_axi_bready) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `FAWP_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg[7:2] == `FAWP_CFG_OFS >> 2) ?
                   `FAWP_RESP_OKAY : `FAWP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_reg <= `FAWP_CFG_RST;
    end else if (do_write && w_strb0_reg &&
                 aw_addr_reg[7:2] == `FAWP_CFG_OFS >> 2) begin
      cfg_reg <= w_data_reg[6:0];
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;

  always_comb begin
    rd_resp = `FAWP_RESP_OKAY;
    unique case (s_axi_araddr[7:2])
      `FAWP_CFG_OFS >> 2: rd_data = {25'h0000000, cfg_reg};
      `FAWP_STAT_OFS >> 2: rd_data = {16'h0000, last_opc_reg, 6'h00,
                                      seen_reg, last_refused_reg};
      `FAWP_ADDR_OFS >> 2: rd_data = {8'h00, addr_reg};
      `FAWP_CNT_OFS >> 2: rd_data = {started_cnt_reg, refused_cnt_reg};
      default: begin
        rd_data = 32'h00000000;
        rd_resp = `FAWP_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `FAWP_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_resp;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic std_mode;
  assign std_mode = !cfg_reg[`FAWP_CFG_SCHEME];

  sequence ev_wr_s;
    ev && cmd_wr;
  endsequence
  sequence verdict_s;
    ##1 (op_start ^ op_refused);
  endsequence

  verdict_once_a: assert property (ev_wr_s |-> verdict_s)
    else $error("write command got no single verdict");
  no_both_a: assert property (!(op_start && op_refused))
    else $error("start and refusal together");
  std_none_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[6:1] == 6'h00) |=> op_start)
    else $error("level zero refused a write");
  cmp_all_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[`FAWP_CFG_CMP] && cfg_reg[`FAWP_CFG_LVL] == 3'h0)
      |=> op_refused)
    else $error("complement level zero let a write through");
  gran_top_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[6:1] == 6'h0A && cmd_kind == fawp_op_prog &&
      cmd_addr[21:12] == 10'h3FF) |=> op_refused)
    else $error("top 4 kB not protected");
  gran_bot_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[6:1] == 6'h0E && cmd_kind == fawp_op_prog &&
      cmd_addr[21:12] == 10'h001) |=> op_start)
    else $error("second 4 kB wrongly protected");
  wide32_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[6:1] == 6'h0B && cmd_kind == fawp_op_e32k &&
      cmd_addr[21:15] == 7'h7F) |=> op_start)
    else $error("widened 32 kB window not applied");
  wide64_a: assert property (ev_wr_s and (std_mode &&
      cfg_reg[6:1] == 6'h17 && cmd_kind == fawp_op_e64k &&
      cmd_addr[21:16] == 6'h00) |=> op_start)
    else $error("widened 64 kB window not applied");
  indiv_a: assert property (ev_wr_s and (!std_mode &&
      lock_reg[lock_idx(cmd_addr)]) |=> op_refused)
    else $error("locked block accepted a write");
  lock_set_a: assert property (ev && cmd_kind == fawp_op_lock
      |=> lock_reg[lock_idx(cmd_addr)])
    else $error("lock bit not set");
  unlock_a: assert property (ev && cmd_kind == fawp_op_unlock
      |=> !lock_reg[lock_idx(cmd_addr)] && !op_start && !op_refused)
    else $error("lock bit not cleared");
  lock_rst_a: assert property (@(posedge core_clk)
      $fell(rst) |-> lock_reg == `FAWP_LOCK_RST)
    else $error("lock bits not all set after reset");

endmodule // fawp_top
`default_nettype wire

/* verif/fawp_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
module fawp_spi_host (
  output logic link_sck,
  output logic link_cs_n,
  output logic link_si
);
  logic lclk;

  initial begin
    lclk = 1'b0;
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_si = 1'b0;
  end

  // free-running 64 ns reference; the wire clock moves only inside frames
  always begin
    #32 lclk = ~lclk;
  end

  // opcode byte then 24 address bits, msb first; slow idles sck mid-frame
  task automatic send(input logic [7:0] opc, input logic [23:0] addr,
                      input logic slow);
    logic [31:0] w;
    begin
      w = {opc, addr};
      @(negedge lclk);
      link_cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
        if (slow && i == 23) begin
          repeat (3) @(negedge lclk);
        end
        link_si = w[i];
        @(posedge lclk);
        link_sck = 1'b1;
        @(negedge lclk);
        link_sck = 1'b0;
      end
      link_cs_n = 1'b1;
      // released line must not keep showing the last bit
      link_si = ~w[0];
    end
  endtask
endmodule // fawp_spi_host
`default_nettype wire

/* verif/tb_top.sv */
`include "fawp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fawp_pkg::*;
  logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sck, cs_n, si;
  logic op_start, op_refused, last_ref;
  logic [7:0] awaddr, araddr, last_opc;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [23:0] op_addr;
  fawp_op_e op_kind;
  int num_errors, compares, seen_start, seen_ref, n_start, n_ref;
  localparam logic [7:0] pp = `FAWP_OPC_PP;
  localparam logic [7:0] e4 = `FAWP_OPC_E4K;
  localparam logic [7:0] e32 = `FAWP_OPC_E32K;
  localparam logic [7:0] e64 = `FAWP_OPC_E64K;
  localparam logic [7:0] ops [10] = '{`FAWP_OPC_PP, `FAWP_OPC_PP_DUAL,
    `FAWP_OPC_PP_QUAD, `FAWP_OPC_SEQ_A, `FAWP_OPC_SEQ_B, `FAWP_OPC_E4K,
    `FAWP_OPC_E32K, `FAWP_OPC_E64K, `FAWP_OPC_CHIP_A, `FAWP_OPC_CHIP_B};

  fawp_top u_fawp_top (.core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .link_sck(sck), .link_cs_n(cs_n), .link_si(si), .op_start(op_start),
    .op_refused(op_refused), .op_kind(op_kind), .op_addr(op_addr));
  fawp_spi_host u_fawp_spi_host (.link_sck(sck), .link_cs_n(cs_n),
    .link_si(si));

  always #12.5 core_clk = ~core_clk;

  // pulses last one cycle, so count them as they pass
  always @(posedge core_clk) begin
    if (op_start === 1'b1) begin
      seen_start++;
    end
    if (op_refused === 1'b1) begin
      seen_ref++;
    end
  end

  task automatic summarize;
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    logic aw_ok, w_ok;
    begin
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        if (aw_ok && w_ok && bvalid === 1'b1) begin
          break;
        end
        if (!aw_ok && awready === 1'b1) begin
          aw_ok = 1'b1;
          awvalid <= 1'b0;
        end
        if (!w_ok && wready === 1'b1) begin
          w_ok = 1'b1;
          wvalid <= 1'b0;
        end
      end while (n < 100);
      chk({31'h0, bvalid}, 32'h1, "bvalid");
      chk({30'h0, bresp}, {30'h0, er}, "bresp");
      bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    logic ok;
    begin
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ok = 1'b0;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        if (ok && rvalid === 1'b1) begin
          break;
        end
        if (!ok && arready === 1'b1) begin
          ok = 1'b1;
          arvalid <= 1'b0;
        end
      end while (n < 100);
      chk({31'h0, rvalid}, 32'h1, "rvalid");
      chk(rdata, ed, "rdata");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
      rready <= 1'b0;
    end
  endtask

  task automatic setc(input logic [3:0] m, input logic [2:0] lv);
    axi_wr(`FAWP_CFG_OFS, {25'h0, lv, m}, `FAWP_RESP_OKAY);
  endtask

  function automatic fawp_op_e kind_of(input logic [7:0] o);
    case (o)
      `FAWP_OPC_PP, `FAWP_OPC_PP_DUAL, `FAWP_OPC_PP_QUAD, `FAWP_OPC_SEQ_A,
      `FAWP_OPC_SEQ_B: return fawp_op_prog;
      `FAWP_OPC_E4K: return fawp_op_e4k;
      `FAWP_OPC_E32K: return fawp_op_e32k;
      `FAWP_OPC_E64K: return fawp_op_e64k;
      `FAWP_OPC_CHIP_A, `FAWP_OPC_CHIP_B: return fawp_op_chip;
      `FAWP_OPC_LOCK: return fawp_op_lock;
      `FAWP_OPC_UNLOCK: return fawp_op_unlock;
      default: return fawp_op_none;
    endcase
  endfunction

  // one frame, then the pulse counts, and for known opcodes the kind and address, are compared
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a,
                     input logic xr, input logic slow = 1'b0);
    int s0, r0;
    logic wr;
    fawp_op_e k;
    begin
      k = kind_of(opc);
      wr = k != fawp_op_none && k != fawp_op_lock && k != fawp_op_unlock;
      s0 = seen_start;
      r0 = seen_ref;
      u_fawp_spi_host.send(opc, a, slow);
      repeat (12) @(posedge core_clk);
      chk(32'(seen_start - s0), {31'h0, wr & ~xr}, "start");
      chk(32'(seen_ref - r0), {31'h0, wr & xr}, "refused");
      if (k != fawp_op_none) begin
        chk({29'h0, op_kind}, {29'h0, k}, "kind");
        chk({8'h0, op_addr}, {8'h0, (k == fawp_op_chip) ? 24'h0 : a},
            "addr");
      end
      if (wr) begin
        n_start += xr ? 0 : 1;
        n_ref += xr ? 1 : 0;
        last_opc = opc;
        last_ref = xr;
      end
    end
  endtask

  initial begin
    #1000000;
    num_errors++;
    summarize();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    axi_rd(`FAWP_CFG_OFS, 32'h0, `FAWP_RESP_OKAY);
    axi_rd(`FAWP_STAT_OFS, 32'h0, `FAWP_RESP_OKAY);
    axi_rd(8'h10, 32'h0, `FAWP_RESP_SLVERR);
    axi_wr(`FAWP_STAT_OFS, 32'hFF, `FAWP_RESP_SLVERR);
    axi_wr(8'h10, 32'h1, `FAWP_RESP_SLVERR);
    setc(4'b0001, 3'h0);
    cmd(pp, 24'h3FF000, 1'b1);
    cmd(pp, 24'h200000, 1'b1, 1'b1);
    cmd(8'h03, 24'h000000, 1'b0);
    setc(4'b0000, 3'h0);
    foreach (ops[i]) begin
      cmd(ops[i], 24'h100000, 1'b0);
    end
    setc(4'b0000, 3'h1);
    cmd(pp, 24'h3F0000, 1'b1);
    cmd(pp, 24'h3EFF00, 1'b0);
    setc(4'b0000, 3'h6);
    cmd(pp, 24'h200000, 1'b1);
    cmd(e64, 24'h1F0000, 1'b0);
    setc(4'b0000, 3'h7);
    cmd(pp, 24'h000000, 1'b1);
    setc(4'b1000, 3'h1);
    cmd(pp, 24'h00FF00, 1'b1);
    cmd(pp, 24'h010000, 1'b0);
    setc(4'b0100, 3'h1);
    cmd(pp, 24'h3FF000, 1'b1);
    cmd(pp, 24'h3FEF00, 1'b0);
    cmd(e64, 24'h3F0000, 1'b1);
    setc(4'b0100, 3'h5);
    cmd(pp, 24'h3F8000, 1'b1);
    cmd(pp, 24'h3F7F00, 1'b0);
    setc(4'b0100, 3'h6);
    cmd(pp, 24'h000000, 1'b1);
    setc(4'b1100, 3'h4);
    cmd(pp, 24'h007F00, 1'b1);
    cmd(pp, 24'h008000, 1'b0);
    setc(4'b1100, 3'h1);
    cmd(pp, 24'h001000, 1'b0);
    cmd(pp, 24'h000F00, 1'b1);
    setc(4'b0010, 3'h1);
    cmd(pp, 24'h3F0000, 1'b0);
    cmd(pp, 24'h3EFF00, 1'b1);
    setc(4'b0010, 3'h0);
    cmd(pp, 24'h3FFF00, 1'b1);
    setc(4'b0010, 3'h7);
    cmd(`FAWP_OPC_CHIP_A, 24'h000000, 1'b0);
    setc(4'b1010, 3'h1);
    cmd(pp, 24'h00FF00, 1'b0);
    cmd(pp, 24'h010000, 1'b1);
    setc(4'b0110, 3'h6);
    cmd(pp, 24'h000000, 1'b0);
    setc(4'b0110, 3'h4);
    cmd(pp, 24'h3F8000, 1'b0);
    cmd(pp, 24'h3F7F00, 1'b1);
    setc(4'b1110, 3'h5);
    cmd(pp, 24'h007F00, 1'b0);
    cmd(pp, 24'h008000, 1'b1);
    setc(4'b0110, 3'h1);
    cmd(e4, 24'h3FE000, 1'b1);
    cmd(e32, 24'h3F8000, 1'b0);
    cmd(e32, 24'h3F0000, 1'b1);
    cmd(e64, 24'h3F0000, 1'b0);
    cmd(e64, 24'h3E0000, 1'b1);
    setc(4'b1110, 3'h2);
    cmd(e32, 24'h000000, 1'b0);
    cmd(e32, 24'h008000, 1'b1);
    cmd(e64, 24'h000000, 1'b0);
    cmd(e64, 24'h010000, 1'b1);
    setc(4'b0001, 3'h7);
    cmd(`FAWP_OPC_UNLOCK, 24'h3FF000, 1'b0);
    cmd(pp, 24'h3FF000, 1'b0);
    cmd(pp, 24'h3FE000, 1'b1);
    cmd(`FAWP_OPC_UNLOCK, 24'h000000, 1'b0);
    cmd(pp, 24'h000F00, 1'b0);
    cmd(pp, 24'h001000, 1'b1);
    cmd(`FAWP_OPC_UNLOCK, 24'h120000, 1'b0);
    cmd(e64, 24'h120000, 1'b0);
    cmd(pp, 24'h130000, 1'b1);
    cmd(e64, 24'h3F0000, 1'b1);
    cmd(`FAWP_OPC_CHIP_B, 24'h000000, 1'b1);
    cmd(`FAWP_OPC_LOCK, 24'h3FF000, 1'b0);
    cmd(pp, 24'h3FF000, 1'b1);
    axi_rd(`FAWP_ADDR_OFS, 32'h003FF000, `FAWP_RESP_OKAY);
    axi_rd(`FAWP_STAT_OFS, {16'h0, last_opc, 6'h0, 1'b1, last_ref},
           `FAWP_RESP_OKAY);
    axi_rd(`FAWP_CNT_OFS, {n_start[15:0], n_ref[15:0]},
           `FAWP_RESP_OKAY);
    wstrb <= 4'hE;
    setc(4'b0000, 3'h0);
    wstrb <= 4'hF;
    axi_rd(`FAWP_CFG_OFS, 32'h00000071, `FAWP_RESP_OKAY);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    setc(4'b0001, 3'h0);
    cmd(pp, 24'h000F00, 1'b1);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
